// ===== design/sws_defines.svh
`ifndef SWS_DEFINES_SVH
`define SWS_DEFINES_SVH

// Timing figures in nanoseconds
`define SWS_CLK_PERIOD_NS 10
`define SWS_POR_READY_NS 2000000
`define SWS_SLEEP_EXIT_SETUP_NS 100000
`define SWS_FULL_WAKE_SETUP_NS 4000000
`define SWS_RX_LOW_HOLD_NS 270000
`define SWS_TONE_PERIOD_NS 2000
`define SWS_BIT_WIDTH_NS 250

// Cycle counts derived from the figures (least times round up)
`define SWS_CYC(ns) (((ns) + `SWS_CLK_PERIOD_NS - 1) / `SWS_CLK_PERIOD_NS)
`define SWS_POR_READY_CYC `SWS_CYC(`SWS_POR_READY_NS)
`define SWS_SLEEP_EXIT_CYC `SWS_CYC(`SWS_SLEEP_EXIT_SETUP_NS)
`define SWS_FULL_WAKE_CYC `SWS_CYC(`SWS_FULL_WAKE_SETUP_NS)
`define SWS_RX_LOW_CYC `SWS_CYC(`SWS_RX_LOW_HOLD_NS)
`define SWS_TONE_CYC `SWS_CYC(`SWS_TONE_PERIOD_NS)
`define SWS_BIT_CYC `SWS_CYC(`SWS_BIT_WIDTH_NS)

// Tone counts and power-up supply cycles
`define SWS_WAKE_TONES 4
`define SWS_EXIT_TONES 40
`define SWS_SUPPLY_CYC 16

`endif

// ===== design/sws_pkg.sv
package sws_pkg;

  typedef enum logic [2:0] {
    SWS_POWERUP,
    SWS_SHUTDOWN,
    SWS_WAKING,
    SWS_ACTIVE,
    SWS_SLEEP
  } sws_state_type;

  typedef enum logic [1:0] {
    SWS_TONE_NONE,
    SWS_TONE_WAKE,
    SWS_TONE_EXIT
  } sws_tone_type;

  typedef struct packed {
    logic alwaysOnAnalogSupply;
    logic lowDropoutOutput;
    logic analogRegulator;
    logic digitalRegulator;
    logic references;
  } sws_supply_type;

endpackage : sws_pkg

// ===== design/sws_reclock.sv
`timescale 1ns/10ps
`include "sws_defines.svh"

// Regenerates relayed link bits at a fixed width
module sws_reclock #(
  parameter int BIT_CYC = `SWS_BIT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Link
  input wire logic enable,
  input wire logic bitIn,
  output logic bitOut
);
  localparam int CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);

  logic prev_r, prev_nxt;
  logic busy_r, busy_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic out_r, out_nxt;

  always_comb begin
    prev_nxt = bitIn;
    busy_nxt = busy_r;
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    if (!enable) begin
      busy_nxt = 1'b0;
      out_nxt = 1'b0;
    end else if (!busy_r && (bitIn != prev_r)) begin
      busy_nxt = 1'b1;
      cnt_nxt = '0;
    end else if (busy_r) begin
      if (cnt_r == HALF) begin
        out_nxt = bitIn;
      end
      if (cnt_r == BIT_LAST) begin
        cnt_nxt = '0;
        busy_nxt = (bitIn != out_r) || (bitIn != prev_r);
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prev_r <= 1'b0;
      busy_r <= 1'b0;
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      busy_r <= busy_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign bitOut = out_r;

  // While enabled, output changes only at mid-bit sample point
  AST_RECLOCK_MID: assert property (@(posedge mclk) disable iff (!reset_n)
    (enable && $past(enable) && busy_r && out_r != $past(out_r))
      |-> $past(cnt_r) == HALF)
    else $error("relayed bit changed off the sample point");

endmodule : sws_reclock

// ===== design/sws_wake_seq.sv
`timescale 1ns/10ps
`include "sws_defines.svh"

module sws_wake_seq #(
  parameter int POR_CYC = `SWS_POR_READY_CYC,
  parameter int FULL_CYC = `SWS_FULL_WAKE_CYC,
  parameter int EXIT_CYC = `SWS_SLEEP_EXIT_CYC,
  parameter int RXLOW_CYC = `SWS_RX_LOW_CYC,
  parameter int TONE_CYC = `SWS_TONE_CYC,
  parameter int WAKE_TONES = `SWS_WAKE_TONES,
  parameter int EXIT_TONES = `SWS_EXIT_TONES,
  parameter int BIT_CYC = `SWS_BIT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Host side pins
  input wire logic wakePin,
  input wire logic rxPin,
  input wire logic sleepRequest,
  // Lower link
  input wire logic toneIn,
  input wire logic linkBitIn,
  // Upper link
  output logic toneOut,
  output logic linkBitOut,
  // Status
  output sws_pkg::sws_supply_type supplies,
  output sws_pkg::sws_state_type state,
  output logic commReady,
  output logic reloadDefaults
);
  import sws_pkg::*;

  localparam int TW = 32;
  localparam logic [TW-1:0] POR_LAST = TW'(POR_CYC - 1);
  localparam logic [TW-1:0] FULL_LAST = TW'(FULL_CYC - 1);
  localparam logic [TW-1:0] EXIT_LAST = TW'(EXIT_CYC - 1);
  localparam logic [TW-1:0] RXLOW_LAST = TW'(RXLOW_CYC - 1);
  localparam logic [TW-1:0] RXLOW_END = TW'(RXLOW_CYC);
  localparam logic [TW-1:0] TONE_LAST = TW'(TONE_CYC - 1);
  localparam logic [TW-1:0] SUP_LAST = TW'(`SWS_SUPPLY_CYC - 1);
  localparam logic [7:0] WAKE_N = 8'(WAKE_TONES);
  localparam logic [7:0] EXIT_N = 8'(EXIT_TONES);

  // Pin synchronisers
  logic [1:0] wakeSync_r, rxSync_r, toneSync_r, bitSync_r, sleepSync_r;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wakeSync_r <= 2'h0;
      rxSync_r <= 2'h3;
      toneSync_r <= 2'h0;
      bitSync_r <= 2'h0;
      sleepSync_r <= 2'h0;
    end else begin
      wakeSync_r <= {wakeSync_r[0], wakePin};
      rxSync_r <= {rxSync_r[0], rxPin};
      toneSync_r <= {toneSync_r[0], toneIn};
      bitSync_r <= {bitSync_r[0], linkBitIn};
      sleepSync_r <= {sleepSync_r[0], sleepRequest};
    end
  end
  logic wakeS, rxS, toneS, sleepS;
  assign sleepS = sleepSync_r[1];
  assign wakeS = wakeSync_r[1];
  assign rxS = rxSync_r[1];
  assign toneS = toneSync_r[1];

  // Incoming tone detector: counts clock cycles with line high
  logic toneHiPrev_r, toneHiPrev_nxt;
  logic [TW-1:0] detCnt_r, detCnt_nxt;
  logic [7:0] detTones_r, detTones_nxt;
  logic wakeDet, exitDet;
  always_comb begin
    toneHiPrev_nxt = toneS;
    detCnt_nxt = detCnt_r;
    detTones_nxt = detTones_r;
    wakeDet = 1'b0;
    exitDet = 1'b0;
    if (toneS) begin
      detCnt_nxt = detCnt_r + 1'b1;
    end else if (toneHiPrev_r) begin
      // Pulse ends: TONE_LAST cycles or more is a wake tone, shorter are exit tones
      detTones_nxt = detTones_r + 8'h01;
      if (detCnt_r >= TONE_LAST) begin
        if (detTones_nxt >= WAKE_N) begin
          wakeDet = 1'b1;
        end
      end else begin
        if (detTones_nxt >= EXIT_N) begin
          exitDet = 1'b1;
        end
      end
      detCnt_nxt = '0;
    end
  end

  // Sequencer
  sws_state_type st_r, st_nxt;
  sws_supply_type sup_r, sup_nxt;
  logic [TW-1:0] tim_r, tim_nxt;
  logic ready_r, ready_nxt;
  logic reload_r, reload_nxt;
  logic fullWake_r, fullWake_nxt;
  logic wakePrev_r, wakePrev_nxt;
  logic [TW-1:0] rxLow_r, rxLow_nxt;
  sws_tone_type txKind_r, txKind_nxt;
  logic [7:0] txLeft_r, txLeft_nxt;
  logic [TW-1:0] txCnt_r, txCnt_nxt;
  logic txPhase_r, txPhase_nxt;
  logic toneOut_r, toneOut_nxt;
  logic wakeReq, exitReq;

  always_comb begin
    wakePrev_nxt = wakeS;
    wakeReq = wakeS && !wakePrev_r;
    rxLow_nxt = rxS ? '0 : ((rxLow_r == RXLOW_END) ? rxLow_r : rxLow_r + 1'b1);
    exitReq = !rxS && (rxLow_r == RXLOW_LAST);
    st_nxt = st_r;
    sup_nxt = sup_r;
    tim_nxt = tim_r + 1'b1;
    ready_nxt = ready_r;
    reload_nxt = 1'b0;
    fullWake_nxt = fullWake_r;
    txKind_nxt = txKind_r;
    txLeft_nxt = txLeft_r;
    txCnt_nxt = txCnt_r;
    txPhase_nxt = txPhase_r;
    toneOut_nxt = 1'b0;
    case (st_r)
      SWS_POWERUP: begin
        sup_nxt.alwaysOnAnalogSupply = 1'b1;
        if (tim_r == SUP_LAST) begin
          st_nxt = SWS_SHUTDOWN;
          tim_nxt = '0;
        end
      end
      SWS_SHUTDOWN: begin
        if (!ready_r && tim_r == POR_LAST) begin
          sup_nxt.lowDropoutOutput = 1'b1;
          ready_nxt = 1'b1;
        end
        if (wakeReq || wakeDet) begin
          sup_nxt.analogRegulator = 1'b1;
          sup_nxt.digitalRegulator = 1'b1;
          sup_nxt.references = 1'b1;
          st_nxt = SWS_ACTIVE;
          txKind_nxt = SWS_TONE_WAKE;
          txLeft_nxt = WAKE_N;
          txCnt_nxt = '0;
          txPhase_nxt = 1'b1;
        end
      end
      SWS_SLEEP: begin
        tim_nxt = '0;
        if (wakeReq || wakeDet) begin
          st_nxt = SWS_WAKING;
          fullWake_nxt = 1'b1;
          reload_nxt = 1'b1;
        end else if (exitReq || exitDet) begin
          st_nxt = SWS_WAKING;
          fullWake_nxt = 1'b0;
        end
      end
      SWS_WAKING: begin
        sup_nxt.analogRegulator = 1'b1;
        sup_nxt.digitalRegulator = 1'b1;
        if (fullWake_r ? tim_r == FULL_LAST : tim_r == EXIT_LAST) begin
          st_nxt = SWS_ACTIVE;
          txKind_nxt = fullWake_r ? SWS_TONE_WAKE : SWS_TONE_EXIT;
          txLeft_nxt = fullWake_r ? WAKE_N : EXIT_N;
          txCnt_nxt = '0;
          txPhase_nxt = 1'b1;
        end
      end
      SWS_ACTIVE: begin
        if (sleepS && txKind_r == SWS_TONE_NONE) begin
          st_nxt = SWS_SLEEP;
          sup_nxt.analogRegulator = 1'b0;
          sup_nxt.digitalRegulator = 1'b0;
        end
      end
      default: st_nxt = SWS_SHUTDOWN;
    endcase
    // Tone burst generator: wake tone high one period, exit tones half
    if (txKind_r != SWS_TONE_NONE) begin
      toneOut_nxt = txPhase_r;
      if ((txKind_r == SWS_TONE_WAKE) ? txCnt_r == TONE_LAST
          : txCnt_r == (TONE_LAST >> 1)) begin
        txCnt_nxt = '0;
        txPhase_nxt = !txPhase_r;
        if (!txPhase_r) begin
          txLeft_nxt = txLeft_r - 8'h01;
          if (txLeft_r == 8'h01) begin
            txKind_nxt = SWS_TONE_NONE;
            txPhase_nxt = 1'b0;
          end
        end
      end else begin
        txCnt_nxt = txCnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= SWS_POWERUP;
      sup_r <= '0;
      tim_r <= '0;
      ready_r <= 1'b0;
      reload_r <= 1'b0;
      fullWake_r <= 1'b0;
      wakePrev_r <= 1'b0;
      rxLow_r <= '0;
      txKind_r <= SWS_TONE_NONE;
      txLeft_r <= 8'h00;
      txCnt_r <= '0;
      txPhase_r <= 1'b0;
      toneOut_r <= 1'b0;
      toneHiPrev_r <= 1'b0;
      detCnt_r <= '0;
      detTones_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      sup_r <= sup_nxt;
      tim_r <= tim_nxt;
      ready_r <= ready_nxt;
      reload_r <= reload_nxt;
      fullWake_r <= fullWake_nxt;
      wakePrev_r <= wakePrev_nxt;
      rxLow_r <= rxLow_nxt;
      txKind_r <= txKind_nxt;
      txLeft_r <= txLeft_nxt;
      txCnt_r <= txCnt_nxt;
      txPhase_r <= txPhase_nxt;
      toneOut_r <= toneOut_nxt;
      toneHiPrev_r <= toneHiPrev_nxt;
      detCnt_r <= detCnt_nxt;
      detTones_r <= (st_r == SWS_ACTIVE) ? 8'h00 : detTones_nxt;
    end
  end

  sws_reclock #(.BIT_CYC(BIT_CYC)) relay (
    .mclk(mclk),
    .reset_n(reset_n),
    .enable(ready_r),
    .bitIn(bitSync_r[1]),
    .bitOut(linkBitOut)
  );

  assign toneOut = toneOut_r;
  assign supplies = sup_r;
  assign state = st_r;
  assign commReady = ready_r;
  assign reloadDefaults = reload_r;

  AST_POR_SHUTDOWN: assert property (@(posedge mclk) disable iff (!reset_n)
    $past(st_r) == SWS_POWERUP && st_r != SWS_POWERUP
      |-> st_r == SWS_SHUTDOWN && sup_r.alwaysOnAnalogSupply)
    else $error("power-up did not settle in shutdown");
  AST_READY_LDO: assert property (@(posedge mclk) disable iff (!reset_n)
    ready_r |-> sup_r.lowDropoutOutput && st_r != SWS_POWERUP)
    else $error("ready without low-dropout output");
  AST_WAKE_REGS: assert property (@(posedge mclk) disable iff (!reset_n)
    st_r == SWS_ACTIVE |-> sup_r.analogRegulator && sup_r.digitalRegulator)
    else $error("active with regulators off");
  AST_TONE_START: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(st_r == SWS_ACTIVE) |-> ##1 toneOut_r)
    else $error("no tone after becoming active");
  AST_RELOAD_ONLY_FULL: assert property (@(posedge mclk) disable iff (!reset_n)
    reload_r |-> st_r == SWS_WAKING && fullWake_r)
    else $error("defaults reloaded outside a full wake");
  AST_EXIT_NO_RELOAD: assert property (@(posedge mclk) disable iff (!reset_n)
    st_r == SWS_WAKING && !fullWake_r |-> !reload_r)
    else $error("sleep exit reloaded registers");
  AST_EXIT_TIME: assert property (@(posedge mclk) disable iff (!reset_n)
    st_r == SWS_WAKING && !fullWake_r && tim_r == EXIT_LAST
      |=> st_r == SWS_ACTIVE)
    else $error("sleep exit setup time missed");
  AST_TONE_COUNT: assert property (@(posedge mclk) disable iff (!reset_n)
    txLeft_r <= EXIT_N)
    else $error("tone burst longer than allowed");
  AST_FORWARD: assert property (@(posedge mclk) disable iff (!reset_n)
    st_r == SWS_SHUTDOWN && wakeDet |=> txKind_r == SWS_TONE_WAKE)
    else $error("detected tone not forwarded");

endmodule : sws_wake_seq

// ===== verif/sws_partner.sv
`timescale 1ns/10ps

// Neighbour devices: watches tones going up, sends tones from below
module sws_partner #(
  parameter int TONE_CYC = 6
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Tone lines
  input wire logic toneUp,
  output logic toneDown
);
  int toneCount = 0;
  int lastWidth = 0;
  int run = 0;

  initial toneDown = 1'b0;

  // Count tones and their high widths
  always @(posedge mclk) begin
    if (reset_n === 1'b1 && toneUp === 1'b1) begin
      run <= run + 1;
    end else begin
      if (run != 0) begin
        toneCount <= toneCount + 1;
        lastWidth <= run;
      end
      run <= 0;
    end
  end

  task automatic clear();
    toneCount = 0;
    lastWidth = 0;
  endtask : clear

  // Burst of tones, each followed by one tone period low
  task automatic sendTones(input int highCyc, input int n);
    repeat (n) begin
      toneDown = 1'b1;
      repeat (highCyc) @(negedge mclk);
      toneDown = 1'b0;
      repeat (TONE_CYC) @(negedge mclk);
    end
  endtask : sendTones
endmodule : sws_partner

// ===== verif/stack_wake_sequencer_tb.sv
`timescale 1ns/10ps

module stack_wake_sequencer_tb;
  import sws_pkg::*;
  localparam int TONE = 6;
  localparam int EXITN = 40;
  localparam int WAKEN = 4;
  localparam int BITC = 25;
  localparam int SHORT = TONE / 2;
  logic mclk, reset_n, wakePin, rxPin, sleepRequest, linkBitIn;
  logic toneIn, toneOut, linkBitOut, commReady, reloadDefaults;
  sws_supply_type supplies;
  sws_state_type state;
  int miscompares = 0;
  int nChecks = 0;
  int reloads = 0;
  int cyc;

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  sws_wake_seq #(.POR_CYC(20), .FULL_CYC(30), .EXIT_CYC(10),
    .RXLOW_CYC(8), .TONE_CYC(TONE), .WAKE_TONES(WAKEN),
    .EXIT_TONES(EXITN), .BIT_CYC(BITC)) uut (
    .mclk(mclk), .reset_n(reset_n), .wakePin(wakePin), .rxPin(rxPin),
    .sleepRequest(sleepRequest), .toneIn(toneIn), .linkBitIn(linkBitIn),
    .toneOut(toneOut), .linkBitOut(linkBitOut), .supplies(supplies),
    .state(state), .commReady(commReady), .reloadDefaults(reloadDefaults));

  sws_partner #(.TONE_CYC(TONE)) u_partner (.mclk(mclk),
    .reset_n(reset_n), .toneUp(toneOut), .toneDown(toneIn));

  always @(posedge mclk) begin
    if (reloadDefaults === 1'b1) reloads <= reloads + 1;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic waitState(input sws_state_type s, input int bound);
    cyc = 0;
    while (state !== s && cyc < bound) begin
      @(negedge mclk);
      cyc++;
    end
    if (state !== s) begin
      miscompares++;
      $display("ERROR %0t state wait timed out", $time);
      final_report();
    end
  endtask : waitState

  task automatic waitTones(input int n, input int hi);
    repeat (n * (hi + TONE) + 4 * TONE + 10) @(negedge mclk);
    check(u_partner.toneCount, n);
    check(u_partner.lastWidth, hi);
  endtask : waitTones

  task automatic goSleep();
    sleepRequest = 1'b1;
    waitState(SWS_SLEEP, 50);
    sleepRequest = 1'b0;
    reloads = 0;
    u_partner.clear();
  endtask : goSleep

  task automatic powerUp();
    @(negedge mclk);
    check(supplies.alwaysOnAnalogSupply, 1);
    check(commReady, 0);
    waitState(SWS_SHUTDOWN, 20);
    check(commReady, 0);
    cyc = 0;
    while (commReady !== 1'b1 && cyc < 40) begin
      @(negedge mclk);
      cyc++;
    end
    check(cyc >= 19 && cyc <= 21, 1);
    check(state, SWS_SHUTDOWN);
  endtask : powerUp

  task automatic wakeShutdown();
    u_partner.clear();
    wakePin = 1'b1;
    waitState(SWS_ACTIVE, 6);
    check(cyc <= 4, 1);
    check(supplies, 5'h1f);
    wakePin = 1'b0;
    waitTones(WAKEN, TONE);
  endtask : wakeShutdown

  task automatic sleepExit();
    goSleep();
    rxPin = 1'b0;
    repeat (6) @(negedge mclk);
    rxPin = 1'b1;
    repeat (12) @(negedge mclk);
    check(state, SWS_SLEEP);
    rxPin = 1'b0;
    repeat (10) @(negedge mclk);
    rxPin = 1'b1;
    waitState(SWS_ACTIVE, 40);
    check(cyc <= 10, 1);
    waitTones(EXITN, SHORT);
    check(reloads, 0);
  endtask : sleepExit

  task automatic fullWake();
    goSleep();
    wakePin = 1'b1;
    waitState(SWS_ACTIVE, 50);
    check(cyc >= 30, 1);
    wakePin = 1'b0;
    waitTones(WAKEN, TONE);
    check(reloads, 1);
  endtask : fullWake

  task automatic toneWake();
    goSleep();
    u_partner.sendTones(SHORT, EXITN);
    waitState(SWS_ACTIVE, 30);
    waitTones(EXITN, SHORT);
    check(reloads, 0);
  endtask : toneWake

  task automatic runLen(input logic lvl, input int exp);
    cyc = 0;
    while (linkBitOut === lvl && cyc < 300) begin
      @(negedge mclk);
      cyc++;
    end
    check(cyc, exp);
  endtask : runLen

  task automatic relay();
    logic [4:0] pat;
    pat = 5'h16;
    fork
      begin
        for (int i = 4; i >= 0; i--) begin
          linkBitIn = pat[i];
          repeat (BITC) @(negedge mclk);
        end
        linkBitIn = 1'b0;
      end
      begin
        cyc = 0;
        while (linkBitOut !== 1'b1 && cyc < 200) begin
          @(negedge mclk);
          cyc++;
        end
        runLen(1'b1, BITC);
        runLen(1'b0, BITC);
        runLen(1'b1, 2 * BITC);
      end
    join
  endtask : relay

  // Mid-run reset, then wake from shutdown by tones from below
  task automatic resetWake();
    @(negedge mclk);
    reset_n = 1'b0;
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    powerUp();
    u_partner.clear();
    u_partner.sendTones(TONE, WAKEN);
    waitState(SWS_ACTIVE, 30);
    waitTones(WAKEN, TONE);
  endtask : resetWake

  initial begin
    reset_n = 1'b0;
    wakePin = 1'b0;
    rxPin = 1'b1;
    sleepRequest = 1'b0;
    linkBitIn = 1'b0;
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    powerUp();
    wakeShutdown();
    sleepExit();
    fullWake();
    toneWake();
    relay();
    resetWake();
    final_report();
  end
endmodule : stack_wake_sequencer_tb
